//--- rtl/feature_id_cfg.svh
// Selector codes, field positions and constant values of the feature bank.
`ifndef FEATURE_ID_CFG_SVH
`define FEATURE_ID_CFG_SVH

// ****************************************************************
// Coprocessor selectors
// ****************************************************************
`define FID_COPROC_NUM      4'hf
`define FID_OPC1            3'h0
`define FID_PRIMARY_SEL     4'h0
`define FID_SECONDARY_SEL   4'h1
`define FID_OPC2_AUX        3'h3
`define FID_OPC2_MMF0       3'h4
`define FID_OPC2_MMF1       3'h5

// ****************************************************************
// Processor mode codes
// ****************************************************************
`define FID_MODE_USER       5'h10

// ****************************************************************
// Register values
// ****************************************************************
`define FID_AUX_VALUE       32'h0000_0000
`define FID_AUX_RSVD_MSB    31
`define FID_AUX_RSVD_LSB    16
`define FID_MMF0_VIRT_MEM   4'h3
`define FID_MMF0_PROT_MEM   4'h0
`define FID_MMF0_COH_CPU    4'h0
`define FID_MMF0_COH_DMA    4'h0
`define FID_MMF0_TIGHT_MEM  4'h3
`define FID_MMF0_AUXCTL     4'h1
`define FID_MMF0_FAST_SW    4'h1
`define FID_MMF0_RSVD       4'h0
`define FID_MMF1_ADDR_HARV  4'h2
`define FID_MMF1_ADDR_UNI   4'h0
`define FID_MMF1_SW_HARV    4'h3
`define FID_MMF1_SW_UNI     4'h0
`define FID_MMF1_ALL_HARV   4'h3
`define FID_MMF1_ALL_UNI    4'h0
`define FID_MMF1_TEST_CLEAN 4'h0
`define FID_MMF1_BTB        4'h1

`endif

//--- rtl/feature_id_pkg.sv
// Types shared by the feature identification bank.
`default_nettype none

package feature_id_pkg;

  // Coprocessor register transfer request from the core.
  typedef struct packed {
    logic       valid;
    logic       is_write;
    logic [4:0] mode;
    logic       nonsecure;
    logic [3:0] coproc;
    logic [2:0] opc1;
    logic [3:0] primary_sel;
    logic [3:0] secondary_sel;
    logic [2:0] opc2;
  } cp_req_s;

  // Answer of the bank to one request.
  typedef struct packed {
    logic        hit;
    logic        undef;
    logic [31:0] data;
  } cp_rsp_s;

  // Which register a request selects.
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_AUX,
    SEL_MMF0,
    SEL_MMF1
  } reg_sel_e;

endpackage : feature_id_pkg
`default_nettype wire

//--- rtl/feature_id_register_bank.sv
// Read-only feature identification bank on the coprocessor transfer port.
`timescale 1ns/1ps
`default_nettype none
`include "feature_id_cfg.svh"

module feature_id_register_bank
  import feature_id_pkg::*;
(
  // Clock and reset
  input  wire logic    clock,
  input  wire logic    rst_n,
  // Coprocessor transfer request
  input  wire cp_req_s req,
  // Registered answer, one cycle after the request
  output var  cp_rsp_s rsp
);

  // ****************************************************************
  // Decode
  // ****************************************************************

  // Maps the selector fields of a request to one register of the bank.
  function automatic reg_sel_e decode_sel(input cp_req_s r);
    reg_sel_e s;
    s = SEL_NONE;
    if (r.coproc != `FID_COPROC_NUM || r.opc1 != `FID_OPC1 ||
        r.primary_sel != `FID_PRIMARY_SEL ||
        r.secondary_sel != `FID_SECONDARY_SEL) begin
      s = SEL_NONE;
    end else if (r.opc2 == `FID_OPC2_AUX) begin
      s = SEL_AUX;
    end else if (r.opc2 == `FID_OPC2_MMF0) begin
      s = SEL_MMF0;
    end else if (r.opc2 == `FID_OPC2_MMF1) begin
      s = SEL_MMF1;
    end else begin
      s = SEL_NONE;
    end
    return s;
  endfunction : decode_sel

  // Decoded selection, constant word, mode flag and answer register.
  reg_sel_e    sel;
  logic [31:0] const_word;
  logic        is_user;
  cp_rsp_s     rsp_d;
  cp_rsp_s     rsp_q;

  // Qualifies the selection with valid and flags a user-mode request.
  assign sel     = req.valid ? decode_sel(req) : SEL_NONE;
  assign is_user = (req.mode == `FID_MODE_USER);

  // Looks up the fixed word of the selected register.
  feature_id_values u_values (
    .sel   (sel),
    .value (const_word)
  );

  // ****************************************************************
  // Answer
  // ****************************************************************

  // Builds the answer; both security worlds are treated alike.
  always_comb begin
    rsp_d = '0;
    if (sel != SEL_NONE) begin
      rsp_d.hit = 1'b1;
      if (is_user || req.is_write) begin
        rsp_d.undef = 1'b1;
      end else begin
        rsp_d.data = const_word;
      end
    end
  end

  // Registers the answer so the output comes from a flip-flop.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // Drives the port straight from the answer register.
  assign rsp = rsp_q;

  // ****************************************************************
  // Checks
  // ****************************************************************

  sequence priv_read_s(logic [2:0] op);
    req.valid && !req.is_write && !is_user && req.coproc == 4'hf &&
    req.opc1 == 3'h0 && req.primary_sel == 4'h0 &&
    req.secondary_sel == 4'h1 && req.opc2 == op;
  endsequence

  // A valid request that names one of the three registers of the bank.
  sequence bank_req_s(logic wr_req, logic user_req);
    req.valid && req.is_write == wr_req &&
    (req.mode == 5'h10) == user_req && req.coproc == 4'hf &&
    req.opc1 == 3'h0 && req.primary_sel == 4'h0 &&
    req.secondary_sel == 4'h1 && req.opc2 inside {3'h3, 3'h4, 3'h5};
  endsequence

  // A valid request whose outer selector fields belong to someone else.
  sequence foreign_req_s;
    req.valid && (req.coproc != 4'hf || req.opc1 != 3'h0 ||
                  req.primary_sel != 4'h0 || req.secondary_sel != 4'h1);
  endsequence

  // A quiet answer port: no claim, no exception and no data.
  sequence quiet_rsp_s;
    !rsp.hit && !rsp.undef && rsp.data == 32'h0;
  endsequence

  // A refusal: the bank claims the transfer and raises the exception.
  sequence refused_rsp_s;
    rsp.hit && rsp.undef && rsp.data == 32'h0;
  endsequence

  AST_AUX_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    priv_read_s(3'h3) |=> rsp.hit && !rsp.undef && rsp.data == 32'h0)
    else $error("auxiliary word not zero");
  AST_AUX_RSVD: assert property (@(posedge clock) disable iff (!rst_n)
    priv_read_s(3'h3) |=> rsp.data[31:16] == 16'h0 && rsp.data[15:0] == 16'h0)
    else $error("auxiliary fields not zero");
  AST_USER_UNDEF: assert property (@(posedge clock) disable iff (!rst_n)
    (sel != SEL_NONE && is_user) |=> refused_rsp_s)
    else $error("user access not undefined");
  AST_WRITE_UNDEF: assert property (@(posedge clock)
    disable iff (!rst_n) (sel != SEL_NONE && req.is_write) |=> refused_rsp_s)
    else $error("write not undefined");
  AST_MMF0_LOW: assert property (@(posedge clock) disable iff (!rst_n)
    priv_read_s(3'h4) |=> rsp.data[3:0] == 4'h3 && !rsp.undef)
    else $error("memory zero low nibble wrong");
  AST_MMF0_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
    priv_read_s(3'h4) |=> rsp.data[31:24] == 8'h01)
    else $error("memory zero top byte wrong");
  AST_MMF0_WORD: assert property (@(posedge clock) disable iff (!rst_n)
    priv_read_s(3'h4) |=> rsp.data[23:16] == 8'h13 && rsp.data[15:4] == 12'h0)
    else $error("memory zero middle fields wrong");
  AST_MMF1_WORD: assert property (@(posedge clock) disable iff (!rst_n)
    priv_read_s(3'h5) |=> rsp.data == 32'h1003_0302)
    else $error("memory one word wrong");
  AST_UNLISTED: assert property (@(posedge clock) disable iff (!rst_n)
    (req.valid && req.opc2 > 3'h5) |=> quiet_rsp_s)
    else $error("unlisted selector answered");

  // Reset clears the answer, and the first edge after release is quiet.
  AST_RESET_QUIET: assert property (@(posedge clock)
    !rst_n |=> quiet_rsp_s)
    else $error("answer not cleared by reset");
  AST_RELEASE_QUIET: assert property (@(posedge clock)
    $rose(rst_n) |-> quiet_rsp_s)
    else $error("answer present at reset release");

  // No request, or a request that is not ours, leaves the port quiet.
  AST_IDLE_QUIET: assert property (@(posedge clock)
    disable iff (!rst_n) !req.valid |=> quiet_rsp_s)
    else $error("answer without a request");
  AST_FOREIGN_QUIET: assert property (@(posedge clock)
    disable iff (!rst_n) foreign_req_s |=> quiet_rsp_s)
    else $error("foreign selector answered");
  AST_LOW_OPC2_QUIET: assert property (@(posedge clock)
    disable iff (!rst_n) (req.valid && req.opc2 < 3'h3) |=> quiet_rsp_s)
    else $error("low second opcode answered");

  // Mode and direction decide between data and the exception.
  AST_USER_READ_UNDEF: assert property (@(posedge clock)
    disable iff (!rst_n) bank_req_s(1'b0, 1'b1) |=> refused_rsp_s)
    else $error("user read not refused");
  AST_USER_WRITE_UNDEF: assert property (@(posedge clock)
    disable iff (!rst_n) bank_req_s(1'b1, 1'b1) |=> refused_rsp_s)
    else $error("user write not refused");
  AST_PRIV_WRITE_UNDEF: assert property (@(posedge clock)
    disable iff (!rst_n) bank_req_s(1'b1, 1'b0) |=> refused_rsp_s)
    else $error("privileged write not refused");
  AST_PRIV_READ_HIT: assert property (@(posedge clock)
    disable iff (!rst_n) bank_req_s(1'b0, 1'b0) |=> rsp.hit && !rsp.undef)
    else $error("privileged read not answered");

  // Field by field checks of memory word zero.
  AST_MMF0_AUX_CTL: assert property (@(posedge clock)
    disable iff (!rst_n) priv_read_s(3'h4) |=> rsp.data[23:20] == 4'h1)
    else $error("memory zero control nibble wrong");
  AST_MMF0_TIGHT: assert property (@(posedge clock)
    disable iff (!rst_n) priv_read_s(3'h4) |=> rsp.data[19:16] == 4'h3)
    else $error("memory zero coupled memory nibble wrong");
  AST_MMF0_ZERO_MID: assert property (@(posedge clock)
    disable iff (!rst_n) priv_read_s(3'h4) |=> rsp.data[15:4] == 12'h0)
    else $error("memory zero coherency nibbles not zero");

  // Field by field checks of memory word one.
  AST_MMF1_TOP: assert property (@(posedge clock)
    disable iff (!rst_n) priv_read_s(3'h5) |=> rsp.data[31:28] == 4'h1)
    else $error("memory one top nibble wrong");
  AST_MMF1_ZERO: assert property (@(posedge clock)
    disable iff (!rst_n) priv_read_s(3'h5) |=>
      rsp.data[27:20] == 8'h0 && rsp.data[15:12] == 4'h0 &&
      rsp.data[7:4] == 4'h0)
    else $error("memory one unsupported nibbles not zero");
  AST_MMF1_WHOLE: assert property (@(posedge clock)
    disable iff (!rst_n) priv_read_s(3'h5) |=> rsp.data[19:16] == 4'h3)
    else $error("memory one whole-cache nibble wrong");
  AST_MMF1_SET_WAY: assert property (@(posedge clock)
    disable iff (!rst_n) priv_read_s(3'h5) |=> rsp.data[11:8] == 4'h3)
    else $error("memory one set/way nibble wrong");
  AST_MMF1_ADDR: assert property (@(posedge clock)
    disable iff (!rst_n) priv_read_s(3'h5) |=> rsp.data[3:0] == 4'h2)
    else $error("memory one address nibble wrong");

endmodule : feature_id_register_bank
`default_nettype wire

//--- rtl/feature_id_values.sv
// Constant contents of the three feature identification registers.
`timescale 1ns/1ps
`default_nettype none
`include "feature_id_cfg.svh"

module feature_id_values
  import feature_id_pkg::*;
(
  // Selection
  input  wire reg_sel_e    sel,
  // Constant word for the selection
  output var  logic [31:0] value
);

  // ****************************************************************
  // Value table
  // ****************************************************************

  // Picks the fixed encoding of the selected register.
  always_comb begin
    case (sel)
      SEL_AUX: begin
        value = `FID_AUX_VALUE;
      end
      SEL_MMF0: begin
        value = {`FID_MMF0_RSVD,
                 `FID_MMF0_FAST_SW,
                 `FID_MMF0_AUXCTL,
                 `FID_MMF0_TIGHT_MEM,
                 `FID_MMF0_COH_DMA,
                 `FID_MMF0_COH_CPU,
                 `FID_MMF0_PROT_MEM,
                 `FID_MMF0_VIRT_MEM};
      end
      SEL_MMF1: begin
        value = {`FID_MMF1_BTB,
                 `FID_MMF1_TEST_CLEAN,
                 `FID_MMF1_ALL_UNI,
                 `FID_MMF1_ALL_HARV,
                 `FID_MMF1_SW_UNI,
                 `FID_MMF1_SW_HARV,
                 `FID_MMF1_ADDR_UNI,
                 `FID_MMF1_ADDR_HARV};
      end
      default: begin
        value = 32'h0000_0000;
      end
    endcase
  end

endmodule : feature_id_values
`default_nettype wire

//--- verification/core_model.sv
// Core-side model that issues coprocessor register transfers.
`timescale 1ns/1ps
`default_nettype none
`include "feature_id_cfg.svh"

module core_model
  import feature_id_pkg::*;
(
  // Clock
  input  wire logic    clock,
  // Transfer request toward the bank
  output var  cp_req_s req
);
  initial req = '0;

  // Presents one request for one cycle, then scrambles the idle port.
  task automatic send(input logic wr, input logic [4:0] mode,
                      input logic ns, input logic ok,
                      input logic [2:0] opc2);
    cp_req_s r;
    cp_req_s idle;
    r               = '0;
    r.valid         = 1'b1;
    r.is_write      = wr;
    r.mode          = mode;
    r.nonsecure     = ns;
    r.coproc        = `FID_COPROC_NUM;
    r.opc1          = `FID_OPC1;
    r.primary_sel   = ok ? `FID_PRIMARY_SEL : 4'h7;
    r.secondary_sel = `FID_SECONDARY_SEL;
    r.opc2          = opc2;
    idle            = ~r;
    idle.valid      = 1'b0;
    @(posedge clock);
    req <= r;
    @(posedge clock);
    req <= idle;
  endtask : send
endmodule : core_model
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the feature identification bank.
`timescale 1ns/1ps
`default_nettype none

module testbench
  import feature_id_pkg::*;
;
  typedef struct packed {
    logic       wr;
    logic [4:0] mode;
    logic       ns;
    logic       ok;
    logic [2:0] opc2;
    cp_rsp_s    exp;
  } row_s;

  logic    clock;
  logic    rst_n;
  cp_req_s req;
  cp_rsp_s rsp;
  int      miscompares;
  int      n_checks;
  int      cycles = 0;
  row_s    rows [9];

  core_model core (.clock(clock), .req(req));
  feature_id_register_bank dut (.clock(clock), .rst_n(rst_n),
                                .req(req), .rsp(rsp));

  // Free-running clock at 25 ns.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Compares the answer against its expected value.
  task automatic chk(input string what, input cp_rsp_s exp);
    n_checks++;
    if (rsp !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, rsp);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Cuts a hang short.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      give_verdict();
    end
  end

  // Main sequence: table of reads and refusals, then hand cases.
  initial begin
    miscompares = 0;
    n_checks = 0;
    rst_n = 1'b0;
    rows = '{
      '{1'h0, 5'h13, 1'h0, 1'h1, 3'h3, {2'h2, 32'h00000000}},
      '{1'h0, 5'h1f, 1'h1, 1'h1, 3'h3, {2'h2, 32'h00000000}},
      '{1'h0, 5'h13, 1'h0, 1'h1, 3'h4, {2'h2, 32'h01130003}},
      '{1'h0, 5'h11, 1'h1, 1'h1, 3'h5, {2'h2, 32'h10030302}},
      '{1'h0, 5'h10, 1'h0, 1'h1, 3'h4, {2'h3, 32'h00000000}},
      '{1'h1, 5'h13, 1'h1, 1'h1, 3'h5, {2'h3, 32'h00000000}},
      '{1'h0, 5'h13, 1'h0, 1'h1, 3'h2, {2'h0, 32'h00000000}},
      '{1'h0, 5'h13, 1'h0, 1'h1, 3'h6, {2'h0, 32'h00000000}},
      '{1'h0, 5'h13, 1'h0, 1'h0, 3'h4, {2'h0, 32'h00000000}}};
    // Reset is held for four edges; the answer is clear when it lifts.
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    #1 chk("reset answer", '0);
    foreach (rows[i]) begin
      core.send(rows[i].wr, rows[i].mode, rows[i].ns, rows[i].ok,
                rows[i].opc2);
      #1 chk("row answer", rows[i].exp);
    end
    // User write is refused, then the answer drops after one cycle.
    core.send(1'b1, 5'h10, 1'b0, 1'b1, 3'h3);
    #1 chk("user write", {2'b11, 32'h0});
    @(posedge clock);
    #1 chk("answer drop", '0);
    // A reset in mid-run swallows a request; a read follows at once.
    rst_n <= 1'b0;
    core.send(1'b0, 5'h13, 1'b0, 1'b1, 3'h4);
    #1 chk("reset swallow", '0);
    rst_n <= 1'b1;
    core.send(1'b0, 5'h1b, 1'b0, 1'b1, 3'h5);
    #1 chk("mmf1 nibbles", {2'b10, 32'h1003_0302});
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
